//--- bench/ddrbsp_ctrl_model.sv
// Purpose: Behavioural memory controller on the link side of the port.
// Assumes: Link period is eight clk_sys cycles (200 ns), running free.
// Notes:   Inputs change midway between link rises for setup and hold.
`timescale 1ns/1ps
`default_nettype none
module ddrbsp_ctrl_model (
  input  wire logic                          clk_sys,
  output var  logic                          link_clk_pos,
  output var  logic                          link_clk_neg,
  output var  logic                          load_strobe_n,
  output var  logic                          read_not_write,
  output var  logic [ddrbsp_pkg::ADDR_W-1:0] addr,
  output var  logic [ddrbsp_pkg::DATA_W-1:0] ctrl_dq,
  output var  logic                          ctrl_oe,
  output var  logic [2:0]                    ph
);
  // ***************************************************************
  // Link clocks and burst driving
  // ***************************************************************
  initial begin
    {ph, link_clk_pos, link_clk_neg, load_strobe_n, read_not_write} = 7'h0B;
    {addr, ctrl_dq, ctrl_oe} = '0;
  end
  // Phase counter, positive rise at phase 0, negative rise at phase 4
  always @(posedge clk_sys) ph <= ph + 3'h1;
  always @(posedge clk_sys) begin
    #2;
    link_clk_pos = ~ph[2];
    link_clk_neg = ph[2];
  end
  task automatic wait_ph(input logic [2:0] p);
    do begin
      @(posedge clk_sys);
      #2;
    end while (ph !== p);
  endtask
  // Ends right after word1 so a following burst can go back to back
  task automatic burst(input logic ld_n, input logic rd, input logic [3:0] a,
                       input logic [17:0] w0, input logic [17:0] w1);
    wait_ph(3'h6);
    {load_strobe_n, read_not_write, addr} = {ld_n, rd, a};
    {ctrl_oe, ctrl_dq} = {~rd, w0};
    wait_ph(3'h2);
    {load_strobe_n, addr, ctrl_dq} = {1'b1, ~a, w1};
  endtask
  // Released lines show the inverse of their last value
  task automatic idle;
    wait_ph(3'h6);
    {ctrl_oe, ctrl_dq, read_not_write} = {1'b0, ~ctrl_dq, ~read_not_write};
  endtask
  // Load low only around a negative rise, which must not start a transfer
  task automatic neg_load(input logic [3:0] a, input logic [17:0] w);
    wait_ph(3'h2);
    {load_strobe_n, read_not_write, addr, ctrl_oe, ctrl_dq} = {2'h0, a, 1'b1, w};
    wait_ph(3'h6);
    {load_strobe_n, ctrl_oe, ctrl_dq} = {2'h2, ~w};
  endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the burst memory port.
// Assumes: Controller model makes 200 ns link clocks from clk_sys.
// Notes:   Read words sampled three quarters of the way through their stand time.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, nrst, pll_disable_pin, link_clk_pos, link_clk_neg, load_strobe_n;
  logic        read_not_write, ctrl_oe, data_oe, output_valid_flag, echo_true, echo_comp;
  logic [3:0]  addr;
  logic [17:0] ctrl_dq, data_out;
  logic [2:0]  ph;
  int          err_total = 0;
  int          n_checks = 0;
  // Shared data wire: controller when writing, the port's drive while data_oe is high, else ctrl_dq
  wire  [17:0] dq = ctrl_oe ? ctrl_dq : (data_oe ? data_out : ctrl_dq);
  ddrbsp_ctrl_model u_ctrl (.clk_sys(clk_sys), .link_clk_pos(link_clk_pos),
    .link_clk_neg(link_clk_neg), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
    .addr(addr), .ctrl_dq(ctrl_dq), .ctrl_oe(ctrl_oe), .ph(ph));
  ddrbsp_port u_dut (.clk_sys(clk_sys), .nrst(nrst), .link_clk_pos(link_clk_pos),
    .link_clk_neg(link_clk_neg), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
    .addr(addr), .data_in(dq), .pll_disable_pin(pll_disable_pin), .data_out(data_out),
    .data_oe(data_oe), .output_valid_flag(output_valid_flag), .echo_strobe_true(echo_true),
    .echo_strobe_comp(echo_comp));
  // ***************************************************************
  // Checks and scenarios
  // ***************************************************************
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #2;
    end
  endtask
  // Counts from the loading positive rise, four clk_sys per half cycle
  task automatic rd_check(input int lat, input logic [17:0] w0, input logic [17:0] w1);
    u_ctrl.wait_ph(3'h6);
    u_ctrl.wait_ph(3'h0);
    steps(4 * lat + 2);
    chk("early", 20'h00000, {18'h00000, output_valid_flag, data_oe});
    steps(4);
    chk("word0", {w0, 2'h3}, {data_out, output_valid_flag, data_oe});
    steps(4);
    chk("word1", {w1, 2'h3}, {data_out, output_valid_flag, data_oe});
    steps(4);
    chk("after", 20'h00000, {18'h00000, output_valid_flag, data_oe});
  endtask
  task automatic do_read(input logic p, input logic [3:0] a, input logic [17:0] w0,
                         input logic [17:0] w1);
    fork
      u_ctrl.burst(1'b0, 1'b1, a, ~w0, ~w1);
      rd_check(p ? 5 : 2, w0, w1);
    join
  endtask
  task automatic t_echo;
    repeat (3) begin
      u_ctrl.wait_ph(3'h1);
      chk("echo_lo", 20'h00001, {18'h00000, echo_true, echo_comp});
      u_ctrl.wait_ph(3'h5);
      chk("echo_hi", 20'h00002, {18'h00000, echo_true, echo_comp});
    end
  endtask
  // Back-to-back writes at both address ends, then reads in reverse order
  task automatic t_wr_rd(input logic p);
    logic [17:0] k;
    k = {18{p}};
    pll_disable_pin = p;
    u_ctrl.burst(1'b0, 1'b0, 4'h0, 18'h15555 ^ k, 18'h2AAAA ^ k);
    u_ctrl.burst(1'b0, 1'b0, 4'hF, 18'h3FFFF ^ k, 18'h00001 ^ k);
    u_ctrl.idle();
    do_read(p, 4'hF, 18'h3FFFF ^ k, 18'h00001 ^ k);
    do_read(p, 4'h0, 18'h15555 ^ k, 18'h2AAAA ^ k);
  endtask
  // A high load and a negative-rise load must leave the stored words alone
  task automatic t_refused;
    pll_disable_pin = 1'b0;
    u_ctrl.burst(1'b0, 1'b0, 4'h5, 18'h0A5A5, 18'h35A5A);
    u_ctrl.burst(1'b1, 1'b0, 4'h5, 18'h11111, 18'h22222);
    u_ctrl.idle();
    u_ctrl.neg_load(4'h5, 18'h33333);
    do_read(1'b0, 4'h5, 18'h0A5A5, 18'h35A5A);
  endtask
  // With the PLL pin low, reads on consecutive positive rises stream four words with no gap
  task automatic t_rd_pair;
    pll_disable_pin = 1'b0;
    fork
      begin
        u_ctrl.burst(1'b0, 1'b1, 4'h0, 18'h00000, 18'h00000);
        u_ctrl.burst(1'b0, 1'b1, 4'h5, 18'h00000, 18'h00000);
      end
      begin
        u_ctrl.wait_ph(3'h6);
        u_ctrl.wait_ph(3'h0);
        steps(14);
        chk("pair_a0", {18'h2AAAA, 2'h3}, {data_out, output_valid_flag, data_oe});
        steps(4);
        chk("pair_a1", {18'h15555, 2'h3}, {data_out, output_valid_flag, data_oe});
        steps(4);
        chk("pair_b0", {18'h0A5A5, 2'h3}, {data_out, output_valid_flag, data_oe});
        steps(4);
        chk("pair_b1", {18'h35A5A, 2'h3}, {data_out, output_valid_flag, data_oe});
        steps(4);
        chk("pair_end", 20'h00000, {18'h00000, output_valid_flag, data_oe});
      end
    join
  endtask
  task automatic close_out;
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    nrst = 1'b0;
    pll_disable_pin = 1'b0;
    repeat (5) @(posedge clk_sys);
    #2;
    chk("reset", 20'h00001, {17'h00000, data_oe, output_valid_flag, echo_comp});
    nrst = 1'b1;
    steps(16);
    t_echo();
    t_wr_rd(1'b0);
    t_wr_rd(1'b1);
    t_refused();
    t_rd_pair();
    close_out();
  end
  // Whole run is near 335 clk_sys; far beyond that means a hang
  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire

//--- include/ddrbsp_pkg.sv
// Purpose: Shared constants for the double-data-rate burst memory port.
// Assumes: Link clocks are sampled by clk_sys (40 MHz), link period 200 ns.
// Notes:   Widths fixed; depth kept small enough for flip-flop storage.
package ddrbsp_pkg;
  // ***************************************************************
  // Geometry
  // ***************************************************************
  localparam int unsigned ADDR_W     = 4;   // Loaded address width
  localparam int unsigned DATA_W     = 18;  // Word width
  localparam int unsigned ARRAY_CNT  = 2;   // Two half-depth arrays
  localparam int unsigned ARRAY_DEP  = 16;  // Words per array
  // ***************************************************************
  // Latency in negative/positive link-clock half cycles
  // ***************************************************************
  localparam logic [2:0]  LAT_PLL_ON  = 3'h5; // Two and a half cycles
  localparam logic [2:0]  LAT_PLL_OFF = 3'h2; // One cycle
  localparam logic [2:0]  LAT_ZERO    = 3'h0;
  localparam logic [2:0]  LAT_ONE     = 3'h1;
  localparam logic        DIR_READ    = 1'b1;
endpackage

//--- verilog/ddrbsp_edge_sync.sv
// Purpose: Two-stage synchroniser with rising-edge pulse for one link clock.
// Assumes: Input is asynchronous to clk_sys.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module ddrbsp_edge_sync (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // ***************************************************************
  // Synchroniser and edge finder
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

//--- verilog/ddrbsp_port.sv
// Purpose: Device side of a two-word-burst double-data-rate memory port.
// Assumes: Link clocks much slower than clk_sys; controller holds inputs
//          stable around each link-clock rising edge.
// Notes:   Latency counted in link half cycles; data pins are split
//          into input, output and output enable.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Address is taken on the positive link clock rise when a load is made.
// - One address bus serves both reads and writes.
// - Storage is two half-depth arrays so one address yields two words.
// - With load low, direction high means read and low means write.
// - Valid flag is high while read data is driven, aligned with echo clocks.
// - Positive clock rises capture inputs and, with the PLL pin low, launch the first read word.
// - Accesses start only on positive clock rises.
// - Negative clock rises capture the second write word and, with the PLL pin low, launch the second read word.
// - Complementary echo clocks run freely, following the positive clock.
// - A low load on a positive rise starts a burst of exactly two words unless, with the PLL pin high, another read loads before it launches.
// - Data outputs are released when no read is being driven.
// - Read latency is two and a half cycles with the PLL pin high, plus a half cycle per write loaded while it waits; one cycle when low.
module ddrbsp_port (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic                          link_clk_pos,
  input  wire logic                          link_clk_neg,
  input  wire logic                          load_strobe_n,
  input  wire logic                          read_not_write,
  input  wire logic [ddrbsp_pkg::ADDR_W-1:0] addr,
  input  wire logic [ddrbsp_pkg::DATA_W-1:0] data_in,
  input  wire logic                          pll_disable_pin,
  output logic      [ddrbsp_pkg::DATA_W-1:0] data_out,
  output logic                               data_oe,
  output logic                               output_valid_flag,
  output logic                               echo_strobe_true,
  output logic                               echo_strobe_comp
);
  typedef enum logic [1:0] {
    DDRBSP_IDLE,
    DDRBSP_WR2
  } ddrbsp_wst_t;

  logic                          kp_lvl;
  logic                          kp_rise;
  logic                          kn_rise;
  logic                          ld_m_reg, ld_s_reg;
  logic                          rw_m_reg, rw_s_reg;
  logic                          pll_m_reg, pll_s_reg;
  logic [ddrbsp_pkg::ADDR_W-1:0] a_m_reg, a_s_reg;
  logic [ddrbsp_pkg::DATA_W-1:0] d_m_reg, d_s_reg;

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  ddrbsp_edge_sync u_sync_pos (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .async_in  (link_clk_pos),
    .level_out (kp_lvl),
    .rise_out  (kp_rise)
  );
  ddrbsp_edge_sync u_sync_neg (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .async_in  (link_clk_neg),
    .level_out (),
    .rise_out  (kn_rise)
  );

  // Pins pass two stages so they line up with the clock edge pulses
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ld_m_reg  <= 1'b1;
      ld_s_reg  <= 1'b1;
      rw_m_reg  <= 1'b0;
      rw_s_reg  <= 1'b0;
      pll_m_reg <= 1'b1;
      pll_s_reg <= 1'b1;
      a_m_reg   <= '0;
      a_s_reg   <= '0;
      d_m_reg   <= '0;
      d_s_reg   <= '0;
    end else begin
      ld_m_reg  <= load_strobe_n;
      ld_s_reg  <= ld_m_reg;
      rw_m_reg  <= read_not_write;
      rw_s_reg  <= rw_m_reg;
      pll_m_reg <= pll_disable_pin;
      pll_s_reg <= pll_m_reg;
      a_m_reg   <= addr;
      a_s_reg   <= a_m_reg;
      d_m_reg   <= data_in;
      d_s_reg   <= d_m_reg;
    end
  end

  // ***************************************************************
  // Storage: two half-depth arrays, word 0 and word 1
  // ***************************************************************
  logic [ddrbsp_pkg::DATA_W-1:0] mem_reg  [ddrbsp_pkg::ARRAY_CNT][ddrbsp_pkg::ARRAY_DEP];
  logic [ddrbsp_pkg::DATA_W-1:0] mem_next [ddrbsp_pkg::ARRAY_CNT][ddrbsp_pkg::ARRAY_DEP];

  ddrbsp_wst_t                   wst_reg, wst_next;
  logic [ddrbsp_pkg::ADDR_W-1:0] wadr_reg, wadr_next;

  // ***************************************************************
  // Read pipeline state
  // ***************************************************************
  logic [2:0]                    rcnt_reg, rcnt_next;   // Half cycles to launch
  logic                          rpend_reg, rpend_next;
  logic [ddrbsp_pkg::ADDR_W-1:0] radr_reg, radr_next;
  logic [ddrbsp_pkg::ADDR_W-1:0] oadr_reg, oadr_next;   // Address of burst on the pins
  logic                          rword_reg, rword_next; // Next word index
  logic [ddrbsp_pkg::DATA_W-1:0] dout_reg, dout_next;
  logic                          oe_reg, oe_next;
  logic                          vld_reg, vld_next;
  logic                          cq_reg, cq_next;
  logic                          half_ev;

  // Any link-clock rise ends a half cycle
  assign half_ev = kp_rise | kn_rise;

  // Latency in half cycles for the current mode
  function automatic logic [2:0] ddrbsp_lat(input logic pll_hi);
    ddrbsp_lat = pll_hi ? ddrbsp_pkg::LAT_PLL_ON : ddrbsp_pkg::LAT_PLL_OFF;
  endfunction

  // ***************************************************************
  // Next-state logic: load, write capture, read launch
  // ***************************************************************
  always_comb begin
    mem_next   = mem_reg;
    wst_next   = wst_reg;
    wadr_next  = wadr_reg;
    rcnt_next  = rcnt_reg;
    rpend_next = rpend_reg;
    radr_next  = radr_reg;
    oadr_next  = oadr_reg;
    rword_next = rword_reg;
    dout_next  = dout_reg;
    oe_next    = oe_reg;
    vld_next   = vld_reg;
    cq_next    = kp_lvl;
    // Second write word rides the negative clock rise
    if (kn_rise && wst_reg == DDRBSP_WR2) begin
      mem_next[1][wadr_reg] = d_s_reg;
      wst_next              = DDRBSP_IDLE;
    end
    if (half_ev) begin
      // Second read word, then release the bus
      if (oe_reg && rword_reg) begin
        dout_next  = mem_reg[1][oadr_reg];
        rword_next = 1'b0;
      end else begin
        oe_next  = 1'b0;
        vld_next = 1'b0;
      end
      if (rpend_reg && rcnt_reg == ddrbsp_pkg::LAT_ONE) begin
        dout_next  = mem_reg[0][radr_reg];
        oadr_next  = radr_reg;                           // Word 1 must not see a newer load
        oe_next    = 1'b1;
        vld_next   = 1'b1;
        rword_next = 1'b1;
        rpend_next = 1'b0;
        rcnt_next  = ddrbsp_pkg::LAT_ZERO;
      end else if (rpend_reg && !(kp_rise && !ld_s_reg)) begin
        rcnt_next = rcnt_reg - ddrbsp_pkg::LAT_ONE;
      end
    end
    // Load decoded last so a read taken at a launch edge is not dropped
    if (kp_rise && !ld_s_reg) begin
      if (rw_s_reg == ddrbsp_pkg::DIR_READ) begin
        rpend_next = 1'b1;
        radr_next  = a_s_reg;
        rcnt_next  = ddrbsp_lat(pll_s_reg);
      end else begin
        mem_next[0][a_s_reg] = d_s_reg;
        wadr_next            = a_s_reg;
        wst_next             = DDRBSP_WR2;
      end
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_reg   <= '{default: '{default: '0}};
      wst_reg   <= DDRBSP_IDLE;
      wadr_reg  <= '0;
      rcnt_reg  <= ddrbsp_pkg::LAT_ZERO;
      rpend_reg <= 1'b0;
      radr_reg  <= '0;
      oadr_reg  <= '0;
      rword_reg <= 1'b0;
      dout_reg  <= '0;
      oe_reg    <= 1'b0;
      vld_reg   <= 1'b0;
      cq_reg    <= 1'b0;
    end else begin
      mem_reg   <= mem_next;
      wst_reg   <= wst_next;
      wadr_reg  <= wadr_next;
      rcnt_reg  <= rcnt_next;
      rpend_reg <= rpend_next;
      radr_reg  <= radr_next;
      oadr_reg  <= oadr_next;
      rword_reg <= rword_next;
      dout_reg  <= dout_next;
      oe_reg    <= oe_next;
      vld_reg   <= vld_next;
      cq_reg    <= cq_next;
    end
  end

  // Outputs come straight from flip-flops, echo_strobe_comp through an inverter
  assign data_out          = dout_reg;
  assign data_oe           = oe_reg;
  assign output_valid_flag = vld_reg;
  assign echo_strobe_true  = cq_reg;
  assign echo_strobe_comp  = ~cq_reg;                    // Inverted copy of one flop

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_valid_with_oe: assert property (@(posedge clk_sys) disable iff (!nrst)
    output_valid_flag == data_oe) else $error("valid flag differs from drive");
  a_idle_bus_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    !data_oe |-> !output_valid_flag) else $error("valid without data");
  a_echo_follows: assert property (@(posedge clk_sys) disable iff (!nrst)
    echo_strobe_true == $past(kp_lvl)) else $error("echo clock not following");
  a_echo_comp_pair: assert property (@(posedge clk_sys) disable iff (!nrst)
    echo_strobe_comp != echo_strobe_true) else $error("echo pair not complementary");
  a_read_arms_lat: assert property (@(posedge clk_sys) disable iff (!nrst)
    (kp_rise && !ld_s_reg && rw_s_reg) |=> (rpend_reg && rcnt_reg == ddrbsp_lat($past(pll_s_reg))))
    else $error("read not loaded with latency");
  a_write_word0: assert property (@(posedge clk_sys) disable iff (!nrst)
    (kp_rise && !ld_s_reg && !rw_s_reg) |=> (mem_reg[0][$past(a_s_reg)] == $past(d_s_reg)
    && wst_reg == DDRBSP_WR2)) else $error("first write word lost");
  a_write_word1: assert property (@(posedge clk_sys) disable iff (!nrst)
    (kn_rise && wst_reg == DDRBSP_WR2 && !(kp_rise && !ld_s_reg && !rw_s_reg))
    |=> (mem_reg[1][$past(wadr_reg)] == $past(d_s_reg))) else $error("second write word lost");
  a_no_load_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!kp_rise && !rpend_reg && !oe_reg) |=> !data_oe) else $error("drive without read");
  a_launch_word0: assert property (@(posedge clk_sys) disable iff (!nrst)
    (half_ev && rpend_reg && rcnt_reg == ddrbsp_pkg::LAT_ONE) |=> (data_oe && rword_reg))
    else $error("read launch missed");
  c_read_burst: cover property (@(posedge clk_sys) disable iff (!nrst)
    data_oe && rword_reg ##[1:40] data_oe && !rword_reg);
  c_write_burst: cover property (@(posedge clk_sys) disable iff (!nrst)
    wst_reg == DDRBSP_WR2 ##[1:40] wst_reg == DDRBSP_IDLE);
  c_fast_mode: cover property (@(posedge clk_sys) disable iff (!nrst)
    rpend_reg && !pll_s_reg);
endmodule
`default_nettype wire
